//--- rtl/bbs_exec.sv
/*
 * bbs_exec: executes the unconditional relative jump and the single bit
 * force high instructions of an 8-bit core, one quarter phase per clock.
 * assumes the fetch logic presents the word at pc - 2 during Q1 and a data
 * memory that answers a read combinationally in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module bbs_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [3:0] bank_select_pointer,
    input wire logic [7:0] mem_rdata,
    output logic [20:0] pc,
    output logic [3:0] phase,
    output logic flush,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic status_we
);

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    function automatic logic is_jump(input logic [15:0] w);
        return w[15:11] == bbs_pkg::OP_JUMP;
    endfunction

    function automatic logic is_setb(input logic [15:0] w);
        return w[15:12] == bbs_pkg::OP_SETB;
    endfunction

    // signed word offset doubled into a byte displacement
    function automatic logic [20:0] jump_disp(input logic [15:0] w);
        logic [20:0] ext;
        ext = {{10{w[10]}}, w[10:0]};
        return {ext[19:0], 1'b0};
    endfunction

    // full data address of register f for the given access bit
    function automatic logic [11:0] data_addr(input logic [15:0] w, input logic [3:0] bsp);
        logic [3:0] bank;
        bank = bsp;
        if (!w[bbs_pkg::ACC_BIT]) begin
            bank = (w[7:0] < bbs_pkg::ACC_SPLIT) ? bbs_pkg::ACC_LOW_BANK
                                                 : bbs_pkg::ACC_HIGH_BANK;
        end
        return {bank, w[7:0]};
    endfunction

    function automatic logic [7:0] bit_mask(input logic [15:0] w);
        return 8'h01 << w[bbs_pkg::BITPOS_LSB +: 3];
    endfunction

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic rst_s1_q, rst_s1_d;
    logic rst_s2_q, rst_s2_d;

    // next values: a one walks in behind the released pin
    always_comb begin
        rst_s1_d = 1'b1;
        rst_s2_d = rst_s1_q;
    end

    // two flops release the reset on the clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= rst_s1_d;
            rst_s2_q <= rst_s2_d;
        end
    end

    // -------------------------------------------------------------
    // execution state
    // -------------------------------------------------------------
    bbs_pkg::bbs_phase_t phase_q, phase_d;
    logic [15:0] ir_q, ir_d;
    logic exec_q, exec_d;
    logic flush_q, flush_d;
    logic [20:0] pc_q, pc_d;
    logic [20:0] target_q, target_d;
    logic [11:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic wr_q, wr_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] wdata_q, wdata_d;

    // next values for one quarter phase
    always_comb begin
        phase_d = phase_q;
        ir_d = ir_q;
        exec_d = exec_q;
        flush_d = flush_q;
        pc_d = pc_q;
        target_d = target_q;
        addr_d = addr_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        rdata_d = rdata_q;
        wdata_d = wdata_q;
        case (phase_q)
            bbs_pkg::BBS_Q1: begin
                phase_d = bbs_pkg::BBS_Q2;
                // decode; the word fetched behind a jump is dropped
                ir_d = instr_word;
                exec_d = instr_valid && !flush_q;
                flush_d = 1'b0;
                if (instr_valid && !flush_q && is_setb(instr_word)) begin
                    addr_d = data_addr(instr_word, bank_select_pointer);
                    rd_d = 1'b1;
                end
            end
            bbs_pkg::BBS_Q2: begin
                phase_d = bbs_pkg::BBS_Q3;
                rdata_d = mem_rdata;
                if (exec_q && is_jump(ir_q)) begin
                    target_d = pc_q + jump_disp(ir_q);
                end
            end
            bbs_pkg::BBS_Q3: begin
                phase_d = bbs_pkg::BBS_Q4;
                if (exec_q && is_setb(ir_q)) begin
                    wdata_d = rdata_q | bit_mask(ir_q);
                    wr_d = 1'b1;
                end
            end
            bbs_pkg::BBS_Q4: begin
                phase_d = bbs_pkg::BBS_Q1;
                if (exec_q && is_jump(ir_q)) begin
                    pc_d = target_q;
                    flush_d = 1'b1;
                end else begin
                    pc_d = pc_q + bbs_pkg::PC_STEP;
                end
            end
            default: begin
                phase_d = bbs_pkg::BBS_Q1;
                exec_d = 1'b0;
            end
        endcase
    end

    // registers of the execution state
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            phase_q <= bbs_pkg::BBS_Q1;
            ir_q <= 16'h0000;
            exec_q <= 1'b0;
            flush_q <= 1'b0;
            pc_q <= bbs_pkg::PC_RESET;
            target_q <= bbs_pkg::PC_RESET;
            addr_q <= 12'h000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            rdata_q <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
            ir_q <= ir_d;
            exec_q <= exec_d;
            flush_q <= flush_d;
            pc_q <= pc_d;
            target_q <= target_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            rdata_q <= rdata_d;
            wdata_q <= wdata_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign pc = pc_q;
    assign phase = phase_q;
    assign flush = flush_q;
    assign mem_addr = addr_q;
    assign mem_rd = rd_q;
    assign mem_wr = wr_q;
    assign mem_wdata = wdata_q;
    assign status_we = 1'b0;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    logic jump_q4;
    assign jump_q4 = (phase_q == bbs_pkg::BBS_Q4) && exec_q && is_jump(ir_q);

    sequence s_rmw;
        rd_q ##2 (wr_q && $stable(addr_q));
    endsequence

    sequence s_dropped;
        flush_q ##1 (!exec_q && phase_q == bbs_pkg::BBS_Q2) ##2 (!flush_q);
    endsequence

    property p_jump_target;
        @(posedge clk) disable iff (!rst_s2_q)
        jump_q4 |=> pc_q == $past(pc_q) + jump_disp($past(ir_q));
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_jump_two_cycles;
        @(posedge clk) disable iff (!rst_s2_q)
        jump_q4 |=> s_dropped;
    endproperty
    a_jump_two_cycles: assert property (p_jump_two_cycles) else $error("no flush cycle");

    property p_pc_step;
        @(posedge clk) disable iff (!rst_s2_q)
        (phase_q == bbs_pkg::BBS_Q4 && !jump_q4) |=> pc_q == $past(pc_q) + bbs_pkg::PC_STEP;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step");

    property p_bit_forced;
        @(posedge clk) disable iff (!rst_s2_q)
        wr_q |-> (wdata_q == ($past(mem_rdata, 2) | bit_mask(ir_q)));
    endproperty
    a_bit_forced: assert property (p_bit_forced) else $error("bit not forced high");

    property p_access_bank;
        @(posedge clk) disable iff (!rst_s2_q)
        (rd_q && !ir_q[bbs_pkg::ACC_BIT]) |->
            addr_q[11:8] == ((ir_q[7:0] < bbs_pkg::ACC_SPLIT) ? bbs_pkg::ACC_LOW_BANK
                                                                : bbs_pkg::ACC_HIGH_BANK);
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

    property p_pointer_bank;
        @(posedge clk) disable iff (!rst_s2_q)
        (rd_q && ir_q[bbs_pkg::ACC_BIT]) |->
            addr_q == {$past(bank_select_pointer), ir_q[7:0]};
    endproperty
    a_pointer_bank: assert property (p_pointer_bank) else $error("pointer bank wrong");

    property p_rmw;
        @(posedge clk) disable iff (!rst_s2_q)
        rd_q |-> s_rmw;
    endproperty
    a_rmw: assert property (p_rmw) else $error("read-modify-write broken");

    property p_flags_kept;
        @(posedge clk) disable iff (!rst_s2_q)
        (wr_q || rd_q) |-> !status_we ##1 !status_we;
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("status flags written");

endmodule

`default_nettype wire

//--- rtl/bbs_pkg.sv
/*
 * bbs_pkg: constants for the branch and bit-set execution block.
 * assumes a core that counts four quarter phases per instruction cycle.
 */
`default_nettype none

package bbs_pkg;

    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int unsigned PC_W = 21;
    localparam int unsigned IW_W = 16;
    localparam int unsigned DA_W = 12;
    localparam int unsigned DD_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned OFF_W = 11;

    // -------------------------------------------------------------
    // opcode fields
    // -------------------------------------------------------------
    localparam logic [4:0] OP_JUMP = 5'h1a;   // 1101 0 in the top five bits
    localparam logic [3:0] OP_SETB = 4'h8;    // 1000 in the top four bits
    localparam int unsigned ACC_BIT = 8;      // bank-access operand
    localparam int unsigned BITPOS_LSB = 9;   // bit position b, three bits

    // -------------------------------------------------------------
    // access bank layout and reset values
    // -------------------------------------------------------------
    localparam logic [7:0] ACC_SPLIT = 8'h80;      // low half bank 0, high half top bank
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;  // one program word

    // -------------------------------------------------------------
    // quarter phases, one-hot
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        BBS_Q1 = 4'b0001,
        BBS_Q2 = 4'b0010,
        BBS_Q3 = 4'b0100,
        BBS_Q4 = 4'b1000
    } bbs_phase_t;

endpackage

`default_nettype wire

//--- dv/tb_top.sv
/*
 * tb_top: self-checking bench for bbs_exec, the jump and bit-set executor.
 * assumes one clock per quarter phase and a combinational data memory,
 * so the bench plays the fetch and memory sides from the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic [3:0] bank_select_pointer = 4'h0;
    logic [7:0] mem_rdata = 8'h00;
    logic [20:0] pc;
    logic [3:0] phase;
    logic flush, mem_rd, mem_wr, status_we;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    bbs_exec bbs_exec_inst (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
        .instr_valid(instr_valid), .bank_select_pointer(bank_select_pointer),
        .mem_rdata(mem_rdata), .pc(pc), .phase(phase), .flush(flush),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .status_we(status_we));

    // ----------------------------------------------------------------
    // clock, hang guard and verdict
    // ----------------------------------------------------------------
    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // scenario tasks
    // ----------------------------------------------------------------
    // align to the falling edge inside a Q1 cycle
    task automatic to_q1();
        int k;
        k = 0;
        while (phase !== 4'b0001 && k < 8) begin
            @(negedge clk);
            k++;
        end
    endtask

    // one bit-set; memory answers in Q2 then the read bus turns to junk
    task automatic bset(input logic [7:0] f, input logic [2:0] b, input logic a,
                        input logic [3:0] ptr, input logic [7:0] rd);
        logic [20:0] p0;
        logic [11:0] ea;
        to_q1();
        p0 = pc;
        ea = a ? {ptr, f} : ((f < bbs_pkg::ACC_SPLIT) ? {bbs_pkg::ACC_LOW_BANK, f}
                                                     : {bbs_pkg::ACC_HIGH_BANK, f});
        instr_word = {bbs_pkg::OP_SETB, b, a, f};
        instr_valid = 1'b1;
        bank_select_pointer = ptr;
        @(negedge clk);
        instr_valid = 1'b0;
        bank_select_pointer = ~ptr;  // pointer only counts at the take edge
        mem_rdata = rd;
        `CHK(mem_rd, 1'b1)
        `CHK(mem_addr, ea)
        @(negedge clk);
        mem_rdata = ~rd;
        `CHK(mem_rd, 1'b0)
        `CHK(mem_wr, 1'b0)
        @(negedge clk);
        `CHK(mem_wr, 1'b1)
        `CHK(mem_wdata, rd | (8'h01 << b))
        `CHK(status_we, 1'b0)
        @(negedge clk);
        `CHK(mem_wr, 1'b0)
        `CHK(pc, p0 + 21'h000002)
        $display("test bset f=%h b=%0d a=%0d done", f, b, a);
    endtask

    // one jump; a bit-set offered in the flushed cycle must be dropped
    task automatic jmp(input logic [10:0] off);
        logic [20:0] tgt;
        to_q1();
        tgt = pc + {{9{off[10]}}, off, 1'b0};
        instr_word = {bbs_pkg::OP_JUMP, off};
        instr_valid = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(pc, tgt)
        `CHK(flush, 1'b1)
        instr_word = {bbs_pkg::OP_SETB, 3'h0, 1'b0, 8'h10};
        @(negedge clk);
        instr_valid = 1'b0;
        `CHK(mem_rd, 1'b0)
        repeat (3) @(negedge clk);
        `CHK(flush, 1'b0)
        `CHK(pc, tgt + 21'h000002)
        $display("test jump off=%h done", off);
    endtask

    // a word that is not executed only lets pc step
    task automatic noop(input logic [15:0] w, input logic v);
        logic [20:0] p0;
        to_q1();
        p0 = pc;
        instr_word = w;
        instr_valid = v;
        @(negedge clk);
        instr_valid = 1'b0;
        `CHK(mem_rd, 1'b0)
        repeat (3) @(negedge clk);
        `CHK(pc, p0 + 21'h000002)
        $display("test noop w=%h v=%0d done", w, v);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        `CHK(phase, 4'b0001)
        `CHK(pc, 21'h000000)
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            bset(8'h7f, i[2:0], 1'b0, 4'h5, 8'h00);
        end
        bset(8'h80, 3'h7, 1'b0, 4'h3, 8'h7f);
        bset(8'hff, 3'h2, 1'b0, 4'h1, 8'hff);
        bset(8'h80, 3'h3, 1'b1, 4'ha, 8'hf0);
        bset(8'h00, 3'h0, 1'b1, 4'hf, 8'hfe);
        jmp(11'h3ff);
        jmp(11'h400);
        jmp(11'h000);
        bset(8'h42, 3'h6, 1'b1, 4'h0, 8'h01);
        noop(16'hffff, 1'b1);
        noop({bbs_pkg::OP_SETB, 3'h1, 1'b0, 8'h20}, 1'b0);
        // reset again mid-run; it must act without a clock edge
        rst_n = 1'b0;
        #1;
        `CHK(pc, 21'h000000)
        `CHK(mem_wr, 1'b0)
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        bset(8'h05, 3'h4, 1'b1, 4'h2, 8'h00);
        $display("test reset again done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
